/* src/adc_defs.svh */
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// register addresses on the internal 8-bit bus
`define ADDR_RES_A_HI 20'hFFFE0
`define ADDR_RES_A_LO 20'hFFFE1
`define ADDR_RES_B_HI 20'hFFFE2
`define ADDR_RES_B_LO 20'hFFFE3
`define ADDR_RES_C_HI 20'hFFFE4
`define ADDR_RES_C_LO 20'hFFFE5
`define ADDR_RES_D_HI 20'hFFFE6
`define ADDR_RES_D_LO 20'hFFFE7
`define ADDR_CSR 20'hFFFE8
`define ADDR_TRG 20'hFFFE9

// result register select bits within the address
`define RES_SEL_MSB 2
`define RES_SEL_LSB 1

// result word layout
`define RES_HI_MSB 9
`define RES_HI_LSB 2
`define RES_LO_MSB 1
`define RES_LO_LSB 0
`define RES_PAD 6'h00

// control/status fields
`define CSR_END_BIT 7
`define CSR_IE_BIT 6
`define CSR_START_BIT 5
`define CSR_SCAN_BIT 4
`define CSR_CKS_BIT 3
`define CSR_GRP_BIT 2
`define CSR_IDX_MSB 1
`define CSR_IDX_LSB 0

// trigger control fields
`define TRG_EN_BIT 7
`define TRG_RSV_BIT 0
`define TRG_ONES 6'h3F

`define RD_UNMAPPED 8'h00

// conversion lengths in states; one state is one core clock
`define STATES_FIRST_SLOW 8'h86
`define STATES_FIRST_FAST 8'h46
`define STATES_NEXT_SLOW 8'h80
`define STATES_NEXT_FAST 8'h42

`endif

/* src/adc_pkg.sv */
package adc_pkg;

   typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} conv_state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic rvalid;
      logic [7:0] rdata;
   } bus_rsp_t;

   typedef struct packed {
      conv_state_t state;
      logic [7:0] cnt;
      logic [1:0] chan;
      logic first;
      logic end_flag;
      logic flag_armed;
      logic irq_en;
      logic start;
      logic scan;
      logic conv_time_select;
      logic grp;
      logic [1:0] idx;
      logic trig_en;
      logic trg_bit0;
      logic pend;
      logic [19:0] pend_addr;
      logic rvalid;
      logic [7:0] rdata;
      logic ans_low;
      logic ans_ctl;
      logic [1:0] temp;
      logic [2:0] pin_sync;
      logic pin_level;
   } ctl_state_t;

   typedef struct packed {
      logic [3:0][9:0] words;
      logic [9:0] rdata;
   } store_state_t;

endpackage : adc_pkg

/* src/result_store.sv */
`include "adc_defs.svh"

module result_store
   import adc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic clear_i,
   input wire logic we_i,
   input wire logic [1:0] waddr_i,
   input wire logic [9:0] wdata_i,
   input wire logic [1:0] raddr_i,
   output logic [9:0] rdata_o
);

   store_state_t s_reg;
   store_state_t s_next;

   always_comb begin
      s_next = s_reg;
      for (int i = 0; i < 4; i++) begin
         if (clear_i) begin
            s_next.words[i] = '0;
         end else if (we_i && waddr_i == i[1:0]) begin
            s_next.words[i] = wdata_i;
         end
      end
      s_next.rdata = s_reg.words[raddr_i];
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata;

endmodule : result_store

/* src/adc_register_control.sv */
// Contract
// - result upper eight bits in high byte, lowest two in bits 7:6 low
// - bits 5 to 0 of each result low byte read as zero
// - input n or n+4 result goes to result register A, B, C, D
// - reset and standby clear all four result registers
// - high byte read directly, low byte delivered from holding register
// - reset and standby clear control/status register to zero
// - end flag sets on single end or after last scanned input
// - end flag clears only by writing 0 after reading it as 1
// - conversion-end interrupt requested only while interrupt enable is 1
// - single mode: start bit stays 1 while converting, auto-clears at end
// - scan mode cycles selected inputs until start bit cleared
// - enabled trigger or timer compare match sets start bit
// - mode bit 0 selects single, 1 selects scan
// - conversion ends within 134 states, or 70 with fast select
// - group bit plus index: single converts k, scan converts 0..k
// - trigger enable gates pin falling edge and timer match starts
// - trigger control bits 6 to 1 read as 1, writes ignored
// - reset and standby restore trigger control to 0x7E
// - high byte read copies low byte into holding register
// - later scan conversions take fixed 128 or 66 states
`include "adc_defs.svh"

module adc_register_control
   import adc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic standby_i,
   input wire bus_req_t bus_req_i,
   output bus_rsp_t bus_rsp_o,
   input wire logic ext_trigger_pin_i,
   input wire logic timer_match_i,
   input wire logic timer_trigger_select_i,
   input wire logic [9:0] conv_data_i,
   output logic [2:0] conv_channel_o,
   output logic conv_busy_o,
   output logic conv_end_irq_o
);

   localparam ctl_state_t CTL_RESET = '0;

   ctl_state_t s_reg;
   ctl_state_t s_next;
   logic done;
   logic pin_fall;
   logic trig_event;
   logic mem_we;
   logic [7:0] limit;
   logic [9:0] mem_rdata;
   logic [7:0] csr_value;

   result_store u_store (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(standby_i),
      .we_i(mem_we),
      .waddr_i(s_reg.chan),
      .wdata_i(conv_data_i),
      .raddr_i(bus_req_i.addr[`RES_SEL_MSB:`RES_SEL_LSB]),
      .rdata_o(mem_rdata)
   );

   assign csr_value = {s_reg.end_flag, s_reg.irq_en, s_reg.start,
                       s_reg.scan, s_reg.conv_time_select, s_reg.grp, s_reg.idx};

   always_comb begin
      s_next = s_reg;
      mem_we = 1'b0;
      pin_fall = 1'b0;

      // first stage feeds only the second; edge taken once 2 and 3 agree
      s_next.pin_sync = {s_reg.pin_sync[1:0], ext_trigger_pin_i};
      if (s_reg.pin_sync[1] == s_reg.pin_sync[2]) begin
         s_next.pin_level = s_reg.pin_sync[2];
         pin_fall = s_reg.pin_level & ~s_reg.pin_sync[2];
      end
      trig_event = s_reg.trig_en & (timer_trigger_select_i ?
                   timer_match_i : pin_fall);

      // first conversion of a sequence is longer than the following ones
      if (s_reg.first) begin
         limit = s_reg.conv_time_select ? `STATES_FIRST_FAST : `STATES_FIRST_SLOW;
      end else begin
         limit = s_reg.conv_time_select ? `STATES_NEXT_FAST : `STATES_NEXT_SLOW;
      end
      done = (s_reg.state == CONV_RUN) && (s_reg.cnt == limit - 8'h01);

      // read answer stage: memory word is ready one cycle after the strobe
      s_next.pend = bus_req_i.rd;
      s_next.pend_addr = bus_req_i.addr;
      s_next.rvalid = s_reg.pend;
      s_next.ans_low = 1'b0;
      s_next.ans_ctl = 1'b0;
      if (s_reg.pend) begin
         case (s_reg.pend_addr)
            `ADDR_RES_A_HI, `ADDR_RES_B_HI, `ADDR_RES_C_HI,
            `ADDR_RES_D_HI: begin
               s_next.rdata = mem_rdata[`RES_HI_MSB:`RES_HI_LSB];
               s_next.temp = mem_rdata[`RES_LO_MSB:`RES_LO_LSB];
            end
            `ADDR_RES_A_LO, `ADDR_RES_B_LO, `ADDR_RES_C_LO,
            `ADDR_RES_D_LO: begin
               // only the holding register answers, so read high first
               s_next.rdata = {s_reg.temp, `RES_PAD};
               s_next.ans_low = 1'b1;
            end
            `ADDR_CSR: begin
               s_next.rdata = csr_value;
               if (s_reg.end_flag) begin
                  s_next.flag_armed = 1'b1;
               end
            end
            `ADDR_TRG: begin
               s_next.rdata = {s_reg.trig_en, `TRG_ONES,
                               s_reg.trg_bit0};
               s_next.ans_ctl = 1'b1;
            end
            default: begin
               s_next.rdata = `RD_UNMAPPED;
            end
         endcase
      end

      // register writes
      if (bus_req_i.wr) begin
         case (bus_req_i.addr)
            `ADDR_CSR: begin
               // writing 1 to the flag does nothing
               if (s_reg.flag_armed && !bus_req_i.wdata[`CSR_END_BIT]) begin
                  s_next.end_flag = 1'b0;
                  s_next.flag_armed = 1'b0;
               end
               s_next.irq_en = bus_req_i.wdata[`CSR_IE_BIT];
               s_next.start = bus_req_i.wdata[`CSR_START_BIT];
               s_next.scan = bus_req_i.wdata[`CSR_SCAN_BIT];
               s_next.conv_time_select = bus_req_i.wdata[`CSR_CKS_BIT];
               s_next.grp = bus_req_i.wdata[`CSR_GRP_BIT];
               s_next.idx = bus_req_i.wdata[`CSR_IDX_MSB:`CSR_IDX_LSB];
            end
            `ADDR_TRG: begin
               s_next.trig_en = bus_req_i.wdata[`TRG_EN_BIT];
               s_next.trg_bit0 = bus_req_i.wdata[`TRG_RSV_BIT];
            end
            default: begin
            end
         endcase
      end

      // a start that arrives while running is simply absorbed
      if (trig_event && !s_reg.start) begin
         s_next.start = 1'b1;
      end

      // conversion sequencer
      case (s_reg.state)
         CONV_IDLE: begin
            if (s_next.start) begin
               s_next.state = CONV_RUN;
               s_next.cnt = '0;
               s_next.first = 1'b1;
               s_next.chan = s_next.scan ? 2'h0 : s_next.idx;
            end
         end
         CONV_RUN: begin
            if (!s_next.start) begin
               // stop discards the conversion in flight
               s_next.state = CONV_IDLE;
            end else if (done) begin
               mem_we = 1'b1;
               s_next.cnt = '0;
               s_next.first = 1'b0;
               if (!s_reg.scan) begin
                  s_next.start = 1'b0;
                  s_next.end_flag = 1'b1;
                  s_next.state = CONV_IDLE;
               end else if (s_reg.chan == s_reg.idx) begin
                  s_next.end_flag = 1'b1;
                  s_next.chan = 2'h0;
               end else begin
                  s_next.chan = s_reg.chan + 2'h1;
               end
            end else begin
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         default: begin
            s_next.state = CONV_IDLE;
         end
      endcase

      // standby acts like reset on everything but the pin synchroniser
      if (standby_i) begin
         s_next = CTL_RESET;
         s_next.pin_sync = {s_reg.pin_sync[1:0], ext_trigger_pin_i};
         s_next.pin_level = s_reg.pin_level;
         mem_we = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= CTL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus_rsp_o = '{rvalid: s_reg.rvalid, rdata: s_reg.rdata};
   assign conv_channel_o = {s_reg.grp, s_reg.chan};
   assign conv_busy_o = (s_reg.state == CONV_RUN);
   assign conv_end_irq_o = s_reg.end_flag & s_reg.irq_en;

   irq_follows_flag_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(s_reg.end_flag) && s_reg.irq_en |-> conv_end_irq_o)
      else $error("interrupt missing after end flag");

   irq_masked_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      !s_reg.irq_en |-> !conv_end_irq_o)
      else $error("interrupt raised while disabled");

   low_pad_zero_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      bus_rsp_o.rvalid && s_reg.ans_low |-> bus_rsp_o.rdata[5:0] == 6'h00)
      else $error("result low byte padding not zero");

   low_from_temp_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      bus_rsp_o.rvalid && s_reg.ans_low |->
      bus_rsp_o.rdata[7:6] == s_reg.temp)
      else $error("low byte not taken from holding register");

   ctl_ones_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      bus_rsp_o.rvalid && s_reg.ans_ctl |->
      bus_rsp_o.rdata[6:1] == 6'h3F)
      else $error("trigger control reserved bits not one");

   single_end_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      done && !s_reg.scan && !standby_i && !bus_req_i.wr |=>
      !s_reg.start && s_reg.end_flag && s_reg.state == CONV_IDLE)
      else $error("single conversion end not flagged");

   slow_time_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(conv_busy_o) && !s_reg.conv_time_select |->
      ##[1:133] (done || !conv_busy_o))
      else $error("slow conversion exceeded 134 states");

   fast_time_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(conv_busy_o) && s_reg.conv_time_select |->
      ##[1:69] (done || !conv_busy_o))
      else $error("fast conversion exceeded 70 states");

   scan_next_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      done && s_reg.scan && !s_reg.conv_time_select && !standby_i &&
      !bus_req_i.wr |->
      ##128 (done || !conv_busy_o || $past(s_reg.conv_time_select)))
      else $error("later scan conversion not 128 states");

   flag_clear_read_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $fell(s_reg.end_flag) |-> $past(s_reg.flag_armed) || $past(standby_i))
      else $error("end flag cleared without prior read");

   flag_cause_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(s_reg.end_flag) |-> $past(done))
      else $error("end flag set without conversion end");

   trig_gate_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      $rose(s_reg.start) && !$past(bus_req_i.wr) |-> $past(s_reg.trig_en))
      else $error("start from disabled trigger");

   no_restart_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      conv_busy_o && !done && trig_event && !bus_req_i.wr && !standby_i
      |=> s_reg.cnt == $past(s_reg.cnt) + 8'h01)
      else $error("trigger disturbed running conversion");

   standby_clear_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      standby_i |=> csr_value == 8'h00 && !s_reg.trig_en)
      else $error("standby did not clear control");

   scan_fast_next_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      done && s_reg.scan && s_reg.conv_time_select && !standby_i &&
      !bus_req_i.wr |->
      ##66 (done || !conv_busy_o || !$past(s_reg.conv_time_select)))
      else $error("later fast scan conversion not 66 states");

   hi_direct_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      bus_rsp_o.rvalid && $past(s_reg.pend_addr) >= `ADDR_RES_A_HI &&
      $past(s_reg.pend_addr) <= `ADDR_RES_D_LO &&
      !$past(s_reg.pend_addr[0]) |->
      bus_rsp_o.rdata == $past(mem_rdata[`RES_HI_MSB:`RES_HI_LSB]))
      else $error("result high byte not taken from stored word");

   temp_load_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      bus_rsp_o.rvalid && $past(s_reg.pend_addr) >= `ADDR_RES_A_HI &&
      $past(s_reg.pend_addr) <= `ADDR_RES_D_LO &&
      !$past(s_reg.pend_addr[0]) |->
      s_reg.temp == $past(mem_rdata[`RES_LO_MSB:`RES_LO_LSB]))
      else $error("holding register not loaded by high byte read");

   chan_single_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      conv_busy_o && !s_reg.scan |-> s_reg.chan == s_reg.idx)
      else $error("single mode converting wrong input");

   chan_scan_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      conv_busy_o && s_reg.scan |-> s_reg.chan <= s_reg.idx)
      else $error("scan mode beyond selected inputs");

   start_held_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      conv_busy_o |-> s_reg.start)
      else $error("start bit low during conversion");

   result_clear_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      standby_i |-> ##2 mem_rdata == 10'h000)
      else $error("standby did not clear results");

   flag_write_one_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      s_reg.end_flag && !standby_i &&
      (!bus_req_i.wr || bus_req_i.wdata[`CSR_END_BIT]) |=> s_reg.end_flag)
      else $error("end flag lost without a clearing write");

   scan_running_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      done && s_reg.scan && !standby_i && !bus_req_i.wr |=>
      conv_busy_o && s_reg.start)
      else $error("scan stopped by itself");

   trig_start_a: assert property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      trig_event && !s_reg.start && !standby_i |=>
      s_reg.start && conv_busy_o)
      else $error("trigger did not start conversion");

endmodule : adc_register_control

/* tb/conv_core_model.sv */
module conv_core_model (
   input wire logic [2:0] channel_i,
   input wire logic busy_i,
   output logic [9:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] level;
   // a distinct value per input, low two bits differ between neighbours
   assign level = {channel_i, channel_i, channel_i, 1'b1};
   // outside a conversion the core output is not valid: show the inverse
   assign data_o = busy_i ? level : ~level;
endmodule : conv_core_model

/* tb/test_adc_register_control.sv */
`include "adc_defs.svh"

module test_adc_register_control import adc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic standby_i = 1'b0;
   bus_req_t req = '0;
   bus_rsp_t rsp;
   logic pin = 1'b1;
   logic tmatch = 1'b0;
   logic tsel = 1'b0;
   logic [9:0] cdata;
   logic [2:0] chan;
   logic busy;
   logic irq;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   // control/status value with start set, then expected busy length
   logic [15:0] rows [8] = '{16'h2086, 16'h6946, 16'h2286, 16'h6B46,
                             16'h2486, 16'h6D46, 16'h2686, 16'h6F46};

   adc_register_control u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .standby_i(standby_i), .bus_req_i(req), .bus_rsp_o(rsp),
      .ext_trigger_pin_i(pin), .timer_match_i(tmatch),
      .timer_trigger_select_i(tsel), .conv_data_i(cdata),
      .conv_channel_o(chan), .conv_busy_o(busy), .conv_end_irq_o(irq));

   conv_core_model u_core (.channel_i(chan), .busy_i(busy), .data_o(cdata));

   always #4 core_clk_i = ~core_clk_i;

   task automatic close_out;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // generous ceiling: the whole sequence needs about 1650 cycles
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step

   // one idle cycle after each write so the strobe is never re-raised
   // in the time step that lowered it
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      step(1);
      req.wr = 1'b0;
      step(1);
   endtask : wr

   task automatic rdc(input logic [19:0] a, input logic [7:0] e);
      int n;
      n = 0;
      req.addr = a;
      req.rd = 1'b1;
      step(1);
      req.rd = 1'b0;
      while (rsp.rvalid !== 1'b1 && n < 6) begin
         step(1);
         n++;
      end
      chk({7'h00, rsp.rvalid, rsp.rdata}, {7'h00, 1'b1, e});
   endtask : rdc

   task automatic wait_busy(input logic v, output int n);
      n = 0;
      while (busy !== v && n < 400) begin
         step(1);
         n++;
      end
   endtask : wait_busy

   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
   endtask : wait_irq

   task automatic cleared;
      for (int i = 0; i < 10; i++) begin
         rdc(20'hFFFE0 + 20'(i), (i == 9) ? 8'h7E : 8'h00);
      end
   endtask : cleared

   initial begin
      int n;
      logic [9:0] e;
      logic [2:0] c;
      logic [7:0] v;
      repeat (6) @(posedge core_clk_i);
      #1;
      rstn_i = 1'b1;
      foreach (rows[i]) begin
         v = rows[i][15:8];
         c = 3'(i);
         e = {c, c, c, 1'b1};
         wr(`ADDR_CSR, v);
         wait_busy(1'b1, n);
         wait_busy(1'b0, n);
         // wait_busy begins one cycle into the conversion
         chk(16'(n + 1), {8'h00, rows[i][7:0]});
         chk({15'h0, irq}, {15'h0, v[6]});
         // flag not yet seen as 1, so this write must leave it set
         wr(`ADDR_CSR, v & 8'h5F);
         rdc(`ADDR_CSR, (v & 8'h5F) | 8'h80);
         wr(`ADDR_CSR, v & 8'h5F);
         rdc(`ADDR_CSR, v & 8'h5F);
         chk({15'h0, irq}, 16'h0000);
         rdc(20'hFFFE0 + 20'(2 * v[1:0]), e[9:2]);
         rdc(20'hFFFE1 + 20'(2 * v[1:0]), {e[1:0], 6'h00});
      end
      // reset while idle, then check every register
      rstn_i = 1'b0;
      step(1);
      rstn_i = 1'b1;
      cleared();
      // scan group 1, inputs 0..2, fast: flag after three conversions
      wr(`ADDR_CSR, 8'h7E);
      wait_irq(n);
      chk({15'h0, n >= 200 && n <= 206}, 16'h0001);
      rdc(`ADDR_CSR, 8'hFE);
      chk({15'h0, busy}, 16'h0001);
      for (int j = 0; j < 4; j++) begin
         c = 3'(4 + j);
         e = (j < 3) ? {c, c, c, 1'b1} : 10'h000;
         rdc(20'hFFFE0 + 20'(2 * j), e[9:2]);
         rdc(20'hFFFE1 + 20'(2 * j), {e[1:0], 6'h00});
      end
      // stop first, mode changes only once start is low
      wr(`ADDR_CSR, 8'h5E);
      wait_busy(1'b0, n);
      chk({15'h0, busy}, 16'h0000);
      rdc(`ADDR_CSR, 8'h5E);
      // slow scan of input 0 alone: first pass long, later ones fixed
      wr(`ADDR_CSR, 8'h70);
      wait_irq(n);
      chk(16'(n + 1), {8'h00, `STATES_FIRST_SLOW});
      rdc(`ADDR_CSR, 8'hF0);
      wr(`ADDR_CSR, 8'h70);
      wait_irq(n);
      // the read and the flag clear took four cycles of the second pass
      chk(16'(n + 4), {8'h00, `STATES_NEXT_SLOW});
      wr(`ADDR_CSR, 8'h50);
      rdc(`ADDR_CSR, 8'hD0);
      chk({15'h0, busy}, 16'h0000);
      wr(`ADDR_CSR, 8'h50);
      // triggers: disabled first, then timer match, then pin
      wr(`ADDR_TRG, 8'h00);
      rdc(`ADDR_TRG, 8'h7E);
      wr(`ADDR_CSR, 8'h0B);
      tsel = 1'b1;
      tmatch = 1'b1;
      step(1);
      tmatch = 1'b0;
      step(4);
      chk({15'h0, busy}, 16'h0000);
      wr(`ADDR_TRG, 8'h80);
      rdc(`ADDR_TRG, 8'hFE);
      tmatch = 1'b1;
      step(1);
      tmatch = 1'b0;
      wait_busy(1'b1, n);
      // a second match during the conversion must not restart it
      tmatch = 1'b1;
      step(1);
      tmatch = 1'b0;
      wait_busy(1'b0, n);
      chk(16'(n + 1), 16'h0046);
      rdc(`ADDR_CSR, 8'h8B);
      wr(`ADDR_CSR, 8'h0B);
      tsel = 1'b0;
      pin = 1'b0;
      wait_busy(1'b1, n);
      chk({15'h0, n < 8}, 16'h0001);
      pin = 1'b1;
      wait_busy(1'b0, n);
      rdc(`ADDR_CSR, 8'h8B);
      // standby pulse clears everything
      standby_i = 1'b1;
      step(1);
      standby_i = 1'b0;
      cleared();
      wr(`ADDR_RES_A_HI, 8'hFF);
      rdc(`ADDR_RES_A_HI, 8'h00);
      rdc(20'hFFFEA, 8'h00);
      close_out();
   end
endmodule : test_adc_register_control
